// [design/res_serial_slave.sv]
// Two-wire serial register port: address match, pointer, writes and reads
`timescale 1ns/10ps
`default_nettype none
module res_serial_slave
	import res_pkg::*;
#(
	parameter logic [6:0] ADDR = res_pkg::DEV_ADDR
) (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic [7:0]      reg_addr,
	output logic            wr_stb,
	output logic [7:0]      wr_data,
	input  wire logic [7:0] rd_data
);
	import res_pkg::*;
	typedef struct packed {
		logic           scl_q;
		logic           sda_q;
		res_ser_state_t st;
		logic [3:0]     cnt;
		logic [7:0]     sh;
		logic           rw;
		logic           nack;
		logic           oe;
		logic [7:0]     ptr;
		logic           stb;
		logic [7:0]     wd;
	} res_ser_t;
	res_ser_t s_r;
	res_ser_t s_nxt;
	logic start_c;
	logic stop_c;
	logic rise_c;
	logic fall_c;
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_q = scl;
		s_nxt.sda_q = sda_in;
		s_nxt.stb = 1'b0;
		start_c = s_r.scl_q & scl & s_r.sda_q & ~sda_in;
		stop_c = s_r.scl_q & scl & ~s_r.sda_q & sda_in;
		rise_c = ~s_r.scl_q & scl;
		fall_c = s_r.scl_q & ~scl;
		if (rise_c && (s_r.st == SS_ADDR || s_r.st == SS_PTR || s_r.st == SS_WDATA)) begin
			s_nxt.sh = {s_r.sh[6:0], sda_in};
			s_nxt.cnt = s_r.cnt + 4'h1;
		end
		unique case (s_r.st)
			SS_IDLE: ;
			SS_ADDR: if (fall_c && s_r.cnt == 4'h8) begin
				if (s_r.sh[7:1] == ADDR) begin
					s_nxt.rw = s_r.sh[0];
					s_nxt.oe = 1'b1;
					s_nxt.st = SS_ADDR_ACK;
				end else begin
					s_nxt.st = SS_IDLE;
				end
			end
			SS_ADDR_ACK: if (fall_c) begin
				s_nxt.cnt = 4'h0;
				if (s_r.rw) begin
					s_nxt.sh = rd_data;
					s_nxt.oe = ~rd_data[7];
					s_nxt.st = SS_RDATA;
				end else begin
					s_nxt.oe = 1'b0;
					s_nxt.st = SS_PTR;
				end
			end
			SS_PTR: if (fall_c && s_r.cnt == 4'h8) begin
				s_nxt.ptr = s_r.sh;
				s_nxt.oe = 1'b1;
				s_nxt.st = SS_PTR_ACK;
			end
			SS_PTR_ACK: if (fall_c) begin
				s_nxt.oe = 1'b0;
				s_nxt.cnt = 4'h0;
				s_nxt.st = SS_WDATA;
			end
			SS_WDATA: if (fall_c && s_r.cnt == 4'h8) begin
				s_nxt.stb = 1'b1;
				s_nxt.wd = s_r.sh;
				s_nxt.oe = 1'b1;
				s_nxt.st = SS_WDATA_ACK;
			end
			SS_WDATA_ACK: if (fall_c) begin
				s_nxt.oe = 1'b0;
				s_nxt.cnt = 4'h0;
				s_nxt.ptr = s_r.ptr + 8'h01;
				s_nxt.st = SS_WDATA;
			end
			SS_RDATA: begin
				if (rise_c) begin
					s_nxt.cnt = s_r.cnt + 4'h1;
				end
				if (fall_c && s_r.cnt == 4'h8) begin
					s_nxt.oe = 1'b0;
					s_nxt.ptr = s_r.ptr + 8'h01;
					s_nxt.st = SS_RACK;
				end else if (fall_c) begin
					s_nxt.sh = {s_r.sh[6:0], 1'b0};
					s_nxt.oe = ~s_r.sh[6];
				end
			end
			SS_RACK: begin
				if (rise_c) begin
					s_nxt.nack = sda_in;
				end
				if (fall_c) begin
					s_nxt.cnt = 4'h0;
					if (s_r.nack) begin
						s_nxt.st = SS_IDLE;
					end else begin
						s_nxt.sh = rd_data;
						s_nxt.oe = ~rd_data[7];
						s_nxt.st = SS_RDATA;
					end
				end
			end
			default: s_nxt.st = SS_IDLE;
		endcase
		// Start and stop override any transfer in progress
		if (start_c) begin
			s_nxt.st = SS_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.oe = 1'b0;
		end else if (stop_c) begin
			s_nxt.st = SS_IDLE;
			s_nxt.oe = 1'b0;
		end
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_r <= '{scl_q: 1'b1, sda_q: 1'b1, st: SS_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = s_r.oe;
	assign reg_addr = s_r.ptr;
	assign wr_stb = s_r.stb;
	assign wr_data = s_r.wd;
endmodule // res_serial_slave
`default_nettype wire

// [pkg/res_pkg.sv]
// Constants, register map and state types of the rail enable sequencer
`default_nettype none
package res_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned HALF_MS_NS     = 500000;
	localparam int unsigned HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;
	// Bus address of the serial port, arbitrary value
	localparam logic [6:0]  DEV_ADDR       = 7'h60;
	localparam int unsigned RAILS          = 4;
	localparam int unsigned RAIL_SDA       = 0;
	localparam int unsigned RAIL_SDB       = 1;
	localparam int unsigned RAIL_LRA       = 2;
	localparam int unsigned RAIL_LRB       = 3;
	localparam logic [7:0]  OFS_LRB_CTRL   = 8'h09;
	localparam logic [7:0]  OFS_LRA_LEVEL  = 8'h0A;
	localparam logic [7:0]  OFS_LRB_LEVEL  = 8'h0B;
	localparam logic [7:0]  OFS_SDA_DELAY  = 8'h0C;
	localparam logic [7:0]  OFS_SDB_DELAY  = 8'h0D;
	localparam logic [7:0]  OFS_LRA_DELAY  = 8'h0E;
	localparam logic [7:0]  OFS_LRB_DELAY  = 8'h0F;
	localparam logic [7:0]  OFS_CONFIG     = 8'h13;
	localparam int unsigned BIT_ON         = 0;
	localparam int unsigned BIT_GATING     = 1;
	localparam int unsigned BIT_DISCHARGE  = 2;
	localparam int unsigned BIT_RISE_SEL   = 6;
	localparam int unsigned BIT_FALL_SEL   = 5;
	localparam int unsigned LEVEL_W        = 5;
	localparam logic [2:0]  RST_LRB_CTRL   = 3'h4;
	localparam logic [4:0]  RST_LEVEL      = 5'h00;
	localparam logic [7:0]  RST_DELAY      = 8'h00;
	localparam logic [1:0]  RST_CONFIG     = 2'h0;
	typedef enum logic [3:0] {
		SS_IDLE     = 4'h0,
		SS_ADDR     = 4'h1,
		SS_ADDR_ACK = 4'h3,
		SS_PTR      = 4'h2,
		SS_PTR_ACK  = 4'h6,
		SS_WDATA    = 4'h7,
		SS_WDATA_ACK = 4'h5,
		SS_RDATA    = 4'h4,
		SS_RACK     = 4'hC
	} res_ser_state_t;
endpackage
`default_nettype wire

// [design/res_top.sv]
// Rail enable sequencer: registers, pin-edge delay timers and rail controls
`timescale 1ns/10ps
`default_nettype none
module res_top #(
	parameter int unsigned HALF_MS_CYCLES = res_pkg::HALF_MS_CYCLES,
	parameter logic [6:0]  ADDR           = res_pkg::DEV_ADDR
) (
	input  wire logic                        mclk,
	input  wire logic                        srst,
	input  wire logic                        en_pin,
	input  wire logic                        scl,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe,
	output logic                             stepdown_a_enable,
	output logic                             stepdown_b_enable,
	output logic                             linreg_a_enable,
	output logic                             linreg_b_enable,
	output logic                             linreg_b_discharge,
	output logic [res_pkg::LEVEL_W-1:0]      linreg_a_level_code,
	output logic [res_pkg::LEVEL_W-1:0]      linreg_b_level_code
);
	import res_pkg::*;
	localparam int unsigned PW = (HALF_MS_CYCLES > 1) ? $clog2(HALF_MS_CYCLES) : 1;
	localparam logic [PW-1:0] PRE_LAST = PW'(HALF_MS_CYCLES - 1);
	if (HALF_MS_CYCLES < 2) begin : g_chk
		$error("HALF_MS_CYCLES must be at least 2");
	end
	typedef struct packed {
		logic [2:0]               lrb_ctrl;
		logic [LEVEL_W-1:0]       lra_level;
		logic [LEVEL_W-1:0]       lrb_level;
		logic [RAILS-1:0][7:0]    delays;
		logic [1:0]               cfg;
		logic                     en_q;
		logic [PW-1:0]            pre;
		logic [RAILS-1:0]         seq_on;
		logic [RAILS-1:0]         busy;
		logic [RAILS-1:0][4:0]    cnt;
		logic [RAILS-1:0]         rail_out;
		logic                     discharge;
	} res_state_t;
	res_state_t r_r;
	res_state_t r_nxt;
	logic [7:0] reg_addr;
	logic       wr_stb;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic       edge_c;
	logic       tick_c;
	logic [3:0] code_c;
	logic       sel_c;
	logic [4:0] tgt_c;
	logic       lrb_on_c;
	res_serial_slave #(.ADDR(ADDR)) res_serial_slave_inst (
		.mclk    (mclk),
		.srst    (srst),
		.scl     (scl),
		.sda_in  (sda_in),
		.sda_out (sda_out),
		.sda_oe  (sda_oe),
		.reg_addr(reg_addr),
		.wr_stb  (wr_stb),
		.wr_data (wr_data),
		.rd_data (rd_data)
	);
	// Read decode, reserved bits and unmapped offsets read zero
	always_comb begin
		rd_data = 8'h00;
		unique case (reg_addr)
			OFS_LRB_CTRL:  rd_data = {5'h00, r_r.lrb_ctrl};
			OFS_LRA_LEVEL: rd_data = {3'h0, r_r.lra_level};
			OFS_LRB_LEVEL: rd_data = {3'h0, r_r.lrb_level};
			OFS_SDA_DELAY: rd_data = r_r.delays[RAIL_SDA];
			OFS_SDB_DELAY: rd_data = r_r.delays[RAIL_SDB];
			OFS_LRA_DELAY: rd_data = r_r.delays[RAIL_LRA];
			OFS_LRB_DELAY: rd_data = r_r.delays[RAIL_LRB];
			OFS_CONFIG: begin
				rd_data[BIT_RISE_SEL] = r_r.cfg[1];
				rd_data[BIT_FALL_SEL] = r_r.cfg[0];
			end
			default: rd_data = 8'h00;
		endcase
	end
	always_comb begin
		r_nxt = r_r;
		code_c = 4'h0;
		sel_c = 1'b0;
		tgt_c = 5'h00;
		// Register writes; level codes keep only bits 4:0
		if (wr_stb) begin
			unique case (reg_addr)
				OFS_LRB_CTRL:  r_nxt.lrb_ctrl = wr_data[2:0];
				OFS_LRA_LEVEL: r_nxt.lra_level = wr_data[LEVEL_W-1:0];
				OFS_LRB_LEVEL: r_nxt.lrb_level = wr_data[LEVEL_W-1:0];
				OFS_SDA_DELAY: r_nxt.delays[RAIL_SDA] = wr_data;
				OFS_SDB_DELAY: r_nxt.delays[RAIL_SDB] = wr_data;
				OFS_LRA_DELAY: r_nxt.delays[RAIL_LRA] = wr_data;
				OFS_LRB_DELAY: r_nxt.delays[RAIL_LRB] = wr_data;
				OFS_CONFIG:    r_nxt.cfg = {wr_data[BIT_RISE_SEL], wr_data[BIT_FALL_SEL]};
				default: ;
			endcase
		end
		// Half-millisecond prescaler, restarted on every pin edge
		r_nxt.en_q = en_pin;
		edge_c = en_pin ^ r_r.en_q;
		tick_c = (r_r.pre == PRE_LAST);
		if (edge_c || tick_c) begin
			r_nxt.pre = '0;
		end else begin
			r_nxt.pre = r_r.pre + PW'(1);
		end
		for (int i = 0; i < RAILS; i++) begin
			// Rise code in bits 3:0, fall code in bits 7:4, range doubles the step
			code_c = r_r.en_q ? r_r.delays[i][3:0] : r_r.delays[i][7:4];
			sel_c = r_r.en_q ? r_r.cfg[1] : r_r.cfg[0];
			tgt_c = sel_c ? {code_c, 1'b0} : {1'b0, code_c};
			if (edge_c) begin
				r_nxt.busy[i] = 1'b1;
				r_nxt.cnt[i] = 5'h00;
			end else if (r_r.busy[i] && r_r.cnt[i] == tgt_c) begin
				r_nxt.busy[i] = 1'b0;
				r_nxt.seq_on[i] = r_r.en_q;
			end else if (r_r.busy[i] && tick_c) begin
				r_nxt.cnt[i] = r_r.cnt[i] + 5'h01;
			end
		end
		r_nxt.rail_out[RAIL_SDA] = r_r.seq_on[RAIL_SDA];
		r_nxt.rail_out[RAIL_SDB] = r_r.seq_on[RAIL_SDB];
		r_nxt.rail_out[RAIL_LRA] = r_r.seq_on[RAIL_LRA];
		lrb_on_c = r_r.lrb_ctrl[BIT_ON] &
			(~r_r.lrb_ctrl[BIT_GATING] | r_r.seq_on[RAIL_LRB]);
		r_nxt.rail_out[RAIL_LRB] = lrb_on_c;
		r_nxt.discharge = ~lrb_on_c & r_r.lrb_ctrl[BIT_DISCHARGE];
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			r_r <= '{lrb_ctrl: RST_LRB_CTRL, lra_level: RST_LEVEL, lrb_level: RST_LEVEL,
				delays: {RAILS{RST_DELAY}}, cfg: RST_CONFIG, default: '0};
		end else begin
			r_r <= r_nxt;
		end
	end
	assign stepdown_a_enable = r_r.rail_out[RAIL_SDA];
	assign stepdown_b_enable = r_r.rail_out[RAIL_SDB];
	assign linreg_a_enable = r_r.rail_out[RAIL_LRA];
	assign linreg_b_enable = r_r.rail_out[RAIL_LRB];
	assign linreg_b_discharge = r_r.discharge;
	assign linreg_a_level_code = r_r.lra_level;
	assign linreg_b_level_code = r_r.lrb_level;
endmodule // res_top
`default_nettype wire

// [verification/res_properties.sv]
// Concurrent checks on the rail sequencer ports
`timescale 1ns/10ps
`default_nettype none
module res_checker (
	input wire logic                        mclk,
	input wire logic                        srst,
	input wire logic                        en_pin,
	input wire logic                        scl,
	input wire logic                        sda_oe,
	input wire logic                        stepdown_a_enable,
	input wire logic                        stepdown_b_enable,
	input wire logic                        linreg_a_enable,
	input wire logic                        linreg_b_enable,
	input wire logic                        linreg_b_discharge,
	input wire logic [res_pkg::LEVEL_W-1:0] linreg_a_level_code,
	input wire logic [res_pkg::LEVEL_W-1:0] linreg_b_level_code
);
	import res_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	property p_sda_seq;
		$changed(stepdown_a_enable) |-> stepdown_a_enable == $past(en_pin, 2);
	endproperty
	a_sda_seq: assert property (p_sda_seq) else $error("stepdown a off pin");
	property p_sdb_seq;
		$changed(stepdown_b_enable) |-> stepdown_b_enable == $past(en_pin, 2);
	endproperty
	a_sdb_seq: assert property (p_sdb_seq) else $error("stepdown b off pin");
	property p_lra_seq;
		$changed(linreg_a_enable) |-> linreg_a_enable == $past(en_pin, 2);
	endproperty
	a_lra_seq: assert property (p_lra_seq) else $error("linreg a off pin");
	property p_disch;
		linreg_b_discharge |-> !linreg_b_enable;
	endproperty
	a_disch: assert property (p_disch) else $error("discharge while on");
	property p_lvla;
		$changed(linreg_a_level_code) |-> sda_oe && !scl;
	endproperty
	a_lvla: assert property (p_lvla) else $error("level a moved outside write");
	property p_lvlb;
		$changed(linreg_b_level_code) |-> sda_oe && !scl;
	endproperty
	a_lvlb: assert property (p_lvlb) else $error("level b moved outside write");
	property p_oe_edge;
		$changed(sda_oe) |-> !scl && !$past(scl);
	endproperty
	a_oe_edge: assert property (p_oe_edge) else $error("data line moved in high clock");
	property p_oe_hold;
		scl && $past(scl) |-> $stable(sda_oe);
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("data line unstable");
endmodule // res_checker
`default_nettype wire

// [verification/res_host_model.sv]
// Host model driving the two-wire register port
`timescale 1ns/10ps
`default_nettype none
module res_host_model (
	input  wire logic mclk,
	input  wire logic sda_line,
	output var logic  scl,
	output var logic  sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic q();
		repeat (4) @(negedge mclk);
	endtask
	// Start or repeated start
	task automatic start();
		sda_drv = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_drv = 1'b0;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_drv = 1'b1;
		q();
	endtask
	// Eight data bits and the acknowledge slot, MSB first
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_drv = tx[i];
			q();
			scl = 1'b1;
			q();
			rx[i] = sda_line;
			scl = 1'b0;
			q();
		end
		sda_drv = 1'b1;
	endtask
endmodule // res_host_model
`default_nettype wire

// [verification/test_res_top.sv]
// Self-checking bench for the rail enable sequencer
`timescale 1ns/10ps
`default_nettype none
module test_res_top;
	import res_pkg::*;
	localparam int unsigned H = 10;
	logic               mclk, srst, en_pin, scl, sda_drv, sda_in;
	wire logic          sda_out, sda_oe, disch;
	wire logic [3:0]    rails;
	wire logic [4:0]    lvl_a, lvl_b;
	int                 failures, n_compared;
	int                 rc [4] = '{1, 15, 0, 2};
	int                 fc [4] = '{2, 3, 1, 5};
	logic               hit;
	assign sda_in = sda_drv & (~sda_oe | sda_out);
	res_top #(.HALF_MS_CYCLES(H)) res_top_inst (
		.mclk(mclk), .srst(srst), .en_pin(en_pin), .scl(scl), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .stepdown_a_enable(rails[0]),
		.stepdown_b_enable(rails[1]), .linreg_a_enable(rails[2]),
		.linreg_b_enable(rails[3]), .linreg_b_discharge(disch),
		.linreg_a_level_code(lvl_a), .linreg_b_level_code(lvl_b));
	res_host_model res_host_model_inst (
		.mclk(mclk), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic sb(input logic [7:0] b);
		logic [8:0] r;
		res_host_model_inst.xfer({b, 1'b1}, r);
		check(16'(r[0]), 16'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		res_host_model_inst.start();
		sb({DEV_ADDR, 1'b0});
		sb(a);
		sb(d);
		res_host_model_inst.stop();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [8:0] r;
		res_host_model_inst.start();
		sb({DEV_ADDR, 1'b0});
		sb(a);
		res_host_model_inst.start();
		sb({DEV_ADDR, 1'b1});
		res_host_model_inst.xfer(9'h1FF, r);
		res_host_model_inst.stop();
		check(16'(r[8:1]), 16'(exp));
	endtask
	// Moves the pin and times every rail from that edge
	task automatic pin(input logic lv, input int mul);
		int t [4];
		t = '{default: 0};
		en_pin = lv;
		for (int n = 1; n <= 400; n++) begin
			@(negedge mclk);
			foreach (t[i]) begin
				if (t[i] == 0 && rails[i] === lv)
					t[i] = n;
			end
		end
		foreach (t[i]) check(16'(t[i]), 16'(3 + mul * H * (lv ? rc[i] : fc[i])));
	endtask
	initial begin
		failures = 0;
		n_compared = 0;
		hit = 1'b0;
		srst = 1'b1;
		en_pin = 1'b0;
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		repeat (2) @(negedge mclk);
		check(16'(disch), 16'h1);
		check(16'({rails, lvl_a, lvl_b}), 16'h0);
		rd(OFS_LRB_CTRL, 8'h04);
		rd(OFS_SDA_DELAY, 8'h00);
		rd(8'h20, 8'h00);
		wr(OFS_LRB_CTRL, 8'h01);
		check(16'({rails[3], disch}), 16'h2);
		wr(OFS_LRB_CTRL, 8'h02);
		check(16'({rails[3], disch}), 16'h0);
		wr(OFS_LRA_LEVEL, 8'h19);
		check(16'(lvl_a), 16'h19);
		rd(OFS_LRA_LEVEL, 8'h19);
		wr(OFS_LRB_LEVEL, 8'hE5);
		check(16'(lvl_b), 16'h05);
		rd(OFS_LRB_LEVEL, 8'h05);
		wr(OFS_SDA_DELAY, 8'h21);
		wr(OFS_SDB_DELAY, 8'h3F);
		wr(OFS_LRA_DELAY, 8'h10);
		wr(OFS_LRB_DELAY, 8'h52);
		wr(OFS_LRB_CTRL, 8'h07);
		check(16'({rails[3], disch}), 16'h1);
		pin(1'b1, 1);
		pin(1'b0, 1);
		check(16'(disch), 16'h1);
		wr(OFS_CONFIG, 8'h60);
		rd(OFS_CONFIG, 8'h60);
		pin(1'b1, 2);
		pin(1'b0, 2);
		wr(OFS_CONFIG, 8'h40);
		rd(OFS_CONFIG, 8'h40);
		pin(1'b1, 2);
		pin(1'b0, 1);
		wr(OFS_CONFIG, 8'h20);
		rd(OFS_CONFIG, 8'h20);
		pin(1'b1, 1);
		pin(1'b0, 2);
		wr(OFS_CONFIG, 8'h00);
		en_pin = 1'b1;
		repeat (8) @(negedge mclk);
		check(16'(rails[2]), 16'h1);
		en_pin = 1'b0;
		repeat (300) begin
			@(negedge mclk);
			if ({rails[3], rails[1:0]} !== 3'h0)
				hit = 1'b1;
		end
		check(16'(hit), 16'h0);
		check(16'(rails), 16'h0);
		wrap_up();
	end
endmodule // test_res_top
bind res_top res_checker res_checker_inst (
	.mclk(mclk), .srst(srst), .en_pin(en_pin), .scl(scl), .sda_oe(sda_oe),
	.stepdown_a_enable(stepdown_a_enable), .stepdown_b_enable(stepdown_b_enable),
	.linreg_a_enable(linreg_a_enable), .linreg_b_enable(linreg_b_enable),
	.linreg_b_discharge(linreg_b_discharge), .linreg_a_level_code(linreg_a_level_code),
	.linreg_b_level_code(linreg_b_level_code));
`default_nettype wire
